// ### include/sfd_pkg.sv
// Shared constants and types for the serial frame link ends
package sfd_pkg;
  // Frame layout, counted in bits
  localparam int ADDR_W = 16;
  localparam int BLK_W = 5;
  localparam int OM_W = 2;
  localparam int BYTE_W = 8;
  localparam int HDR_BITS = 24;
  // Field positions inside the 24-bit header word
  localparam int ADDR_LSB = 8;
  localparam int BLK_LSB = 3;
  localparam int WNR_POS = 2;
  // Link edge indices inside the header and inside a data byte
  localparam logic [4:0] RWB_EDGE = 5'h15;
  localparam logic [4:0] LAST_HDR_EDGE = 5'h17;
  localparam logic [4:0] LAST_BIT = 5'h07;
  localparam logic [4:0] RD_REQ_BIT = 5'h05;
  // Length-mode encodings
  localparam logic [1:0] OM_VAR = 2'h0;
  localparam logic [1:0] OM_ONE = 2'h1;
  localparam logic [1:0] OM_TWO = 2'h2;
  localparam logic [1:0] OM_FOUR = 2'h3;
  // Byte counts of the fixed modes
  localparam logic [7:0] N_ONE = 8'h01;
  localparam logic [7:0] N_TWO = 8'h02;
  localparam logic [7:0] N_FOUR = 8'h04;
  localparam logic WNR_WRITE = 1'b1;
  // Host sequencer states
  typedef enum logic [2:0] {SFD_H_IDLE, SFD_H_LEAD, SFD_H_RUN, SFD_H_TAIL, SFD_H_GAP} sfd_host_st_e;
endpackage

// ### include/sfd_if.sv
// Serial frame link wires between host and target
`timescale 1ns/1ps
`default_nettype none
interface sfd_if;
  logic frame_select_n;
  logic sclk;
  logic mosi;
  logic miso;
  // Target end
  modport dev (input frame_select_n, input sclk, input mosi, output miso);
  // Host end
  modport hst (output frame_select_n, output sclk, output mosi, input miso);
endinterface
`default_nettype wire

// ### hdl/sfd_sync3.sv
// Three-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module sfd_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // Destination clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic [WIDTH-1:0] d_in, // Foreign level
  output logic [WIDTH-1:0] s2_out, // Second stage
  output logic [WIDTH-1:0] s3_out // Third stage
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } sfd_sync_s;

  sfd_sync_s q, n;

  // Stage chain, first stage read only by second
  always_comb begin
    n = q;
    n.s1 = d_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign s2_out = q.s2;
  assign s3_out = q.s3;
endmodule
`default_nettype wire

// ### hdl/sfd_target.sv
// Serial frame target: decodes frames on the link clock, hands writes to the core clock
`timescale 1ns/1ps
`default_nettype none
// Function
// - Select low time sets variable data length
// - Host sends mode bits 00 when variable
// - Write bit one: data bytes are stored
// - Host drops select before first address bit
// - Host bits change on falling clock edge
// - Rising select ends frame, access closes
// - Further write bytes accepted as burst
// - Burst bytes go to incrementing offsets
// - Write bit zero: target returns data
// - Read bits driven for rising-edge sampling
// - Read burst supplies incrementing offset bytes
// - Fixed mode keeps select low except while reset holds it high
// - Fixed mode length from mode bits
// - Fixed frames share variable frame layout
// - Host uses only 1/2/4 fixed lengths
// - Four-byte fixed write uses mode 11
// - Mode 01,10,11 give 1,2,4 bytes
// - Bytes travel most significant bit first
// - Block select picks addressed block
module sfd_target (
  sfd_if.dev lnk, // Serial link, target side
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset, high
  output logic wr_stb_out, // Write pulse, core clock
  output logic [sfd_pkg::ADDR_W-1:0] wr_addr_out, // Write offset
  output logic [sfd_pkg::BLK_W-1:0] wr_block_out, // Write block select
  output logic [sfd_pkg::BYTE_W-1:0] wr_data_out, // Write byte
  output logic rd_req_out, // Read request, link clock
  output logic [sfd_pkg::ADDR_W-1:0] rd_addr_out, // Read offset
  output logic [sfd_pkg::BLK_W-1:0] rd_block_out, // Read block select
  input wire logic [sfd_pkg::BYTE_W-1:0] rd_data_in, // Read byte, link clock
  output logic frame_busy_out // Data phase active, link clock
);
  // Frame state on the link clock, cleared whenever select is high
  typedef struct packed {
    logic in_data;
    logic [4:0] cnt;
    logic [sfd_pkg::ADDR_W-1:0] byte_idx;
    logic [sfd_pkg::HDR_BITS-1:0] hdr;
    logic [sfd_pkg::ADDR_W-1:0] addr;
    logic [sfd_pkg::BLK_W-1:0] blk;
    logic wnr;
    logic [sfd_pkg::OM_W-1:0] om;
    logic [sfd_pkg::BYTE_W-1:0] rd_buf;
    logic miso;
    logic rd_req;
    logic [sfd_pkg::ADDR_W-1:0] rd_addr;
    logic [sfd_pkg::BLK_W-1:0] rd_blk;
  } sfd_lnk_s;

  // Write hand-off on the link clock, survives the end of a frame
  typedef struct packed {
    logic wr_tgl;
    logic [sfd_pkg::ADDR_W-1:0] wr_addr;
    logic [sfd_pkg::BLK_W-1:0] wr_blk;
    logic [sfd_pkg::BYTE_W-1:0] wr_data;
  } sfd_keep_s;

  // Core clock side of the write crossing
  typedef struct packed {
    logic lrst;
    logic last;
    logic stb;
    logic [sfd_pkg::ADDR_W-1:0] addr;
    logic [sfd_pkg::BLK_W-1:0] blk;
    logic [sfd_pkg::BYTE_W-1:0] data;
  } sfd_core_s;

  localparam sfd_core_s CORE_RST = '{lrst: 1'b1, default: '0};

  sfd_lnk_s l_q, l_d;
  sfd_keep_s k_q, k_d;
  sfd_core_s c_q, c_d;
  logic [sfd_pkg::HDR_BITS-1:0] shin;
  logic [sfd_pkg::HDR_BITS-1:0] early;
  logic [sfd_pkg::HDR_BITS-1:0] full;
  logic fixed_last;
  logic lnk_clr;
  logic tgl_s2;
  logic tgl_s3;

  // Byte count of a fixed-length frame
  function automatic logic [7:0] fixed_len(input logic [sfd_pkg::OM_W-1:0] om);
    case (om)
      sfd_pkg::OM_ONE: fixed_len = sfd_pkg::N_ONE;
      sfd_pkg::OM_TWO: fixed_len = sfd_pkg::N_TWO;
      sfd_pkg::OM_FOUR: fixed_len = sfd_pkg::N_FOUR;
      default: fixed_len = '0;
    endcase
  endfunction

  assign lnk_clr = lnk.frame_select_n | c_q.lrst;

  assign shin = {l_q.hdr[sfd_pkg::HDR_BITS-2:0], lnk.mosi};
  assign early = shin << sfd_pkg::OM_W;
  assign full = shin;
  assign fixed_last = (l_q.om != sfd_pkg::OM_VAR) &&
                      ((l_q.byte_idx[7:0] + 8'h01) == fixed_len(l_q.om));

  // Frame decoder, one step per rising link clock edge
  always_comb begin
    l_d = l_q;
    k_d = k_q;
    l_d.rd_req = 1'b0;
    l_d.hdr = shin;
    if (!l_q.in_data) begin
      l_d.cnt = l_q.cnt + 5'h01;
      if (l_q.cnt == sfd_pkg::RWB_EDGE && early[sfd_pkg::WNR_POS] != sfd_pkg::WNR_WRITE) begin
        l_d.rd_req = 1'b1;
        l_d.rd_addr = early[sfd_pkg::ADDR_LSB +: sfd_pkg::ADDR_W];
        l_d.rd_blk = early[sfd_pkg::BLK_LSB +: sfd_pkg::BLK_W];
      end
      if (l_q.cnt == sfd_pkg::LAST_HDR_EDGE) begin
        l_d.addr = full[sfd_pkg::ADDR_LSB +: sfd_pkg::ADDR_W];
        l_d.blk = full[sfd_pkg::BLK_LSB +: sfd_pkg::BLK_W];
        l_d.wnr = full[sfd_pkg::WNR_POS];
        l_d.om = full[sfd_pkg::OM_W-1:0];
        l_d.in_data = 1'b1;
        l_d.cnt = '0;
        l_d.byte_idx = '0;
        if (full[sfd_pkg::WNR_POS] != sfd_pkg::WNR_WRITE) begin
          l_d.rd_buf = rd_data_in;
          l_d.miso = rd_data_in[sfd_pkg::BYTE_W-1];
        end
      end
    end else begin
      l_d.cnt = (l_q.cnt == sfd_pkg::LAST_BIT) ? '0 : l_q.cnt + 5'h01;
      if (l_q.wnr != sfd_pkg::WNR_WRITE) begin
        if (l_q.cnt != sfd_pkg::LAST_BIT) begin
          l_d.rd_buf = {l_q.rd_buf[sfd_pkg::BYTE_W-2:0], 1'b0};
          l_d.miso = l_q.rd_buf[sfd_pkg::BYTE_W-2];
        end
        if (l_q.cnt == sfd_pkg::RD_REQ_BIT && !fixed_last) begin
          l_d.rd_req = 1'b1;
          l_d.rd_addr = l_q.addr + l_q.byte_idx + 16'h0001;
          l_d.rd_blk = l_q.blk;
        end
        if (l_q.cnt == sfd_pkg::LAST_BIT) begin
          l_d.rd_buf = fixed_last ? '0 : rd_data_in;
          l_d.miso = fixed_last ? 1'b0 : rd_data_in[sfd_pkg::BYTE_W-1];
        end
      end
      if (l_q.cnt == sfd_pkg::LAST_BIT) begin
        if (l_q.wnr == sfd_pkg::WNR_WRITE) begin
          k_d.wr_tgl = ~k_q.wr_tgl;
          k_d.wr_addr = l_q.addr + l_q.byte_idx;
          k_d.wr_blk = l_q.blk;
          k_d.wr_data = shin[sfd_pkg::BYTE_W-1:0];
        end
        l_d.byte_idx = l_q.byte_idx + 16'h0001;
        if (fixed_last) begin
          l_d.in_data = 1'b0;
          l_d.cnt = '0;
        end
      end
    end
  end

  // Frame state lives while select low
  always_ff @(posedge lnk.sclk or posedge lnk_clr) begin
    if (lnk_clr) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Write hand-off register, cleared only by reset
  always_ff @(posedge lnk.sclk or posedge c_q.lrst) begin
    if (c_q.lrst) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  // Toggle crossing into the core clock
  sfd_sync3 #(.WIDTH(1)) u_wr_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in(k_q.wr_tgl),
    .s2_out(tgl_s2),
    .s3_out(tgl_s3)
  );

  // Core side: one strobe per toggle change
  always_comb begin
    c_d = c_q;
    c_d.lrst = 1'b0;
    c_d.stb = 1'b0;
    if (tgl_s2 == tgl_s3 && tgl_s3 != c_q.last) begin
      c_d.last = tgl_s3;
      c_d.stb = 1'b1;
      c_d.addr = k_q.wr_addr;
      c_d.blk = k_q.wr_blk;
      c_d.data = k_q.wr_data;
    end
  end

  // Core state register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // Outputs
  assign lnk.miso = l_q.miso;
  assign wr_stb_out = c_q.stb;
  assign wr_addr_out = c_q.addr;
  assign wr_block_out = c_q.blk;
  assign wr_data_out = c_q.data;
  assign rd_req_out = l_q.rd_req;
  assign rd_addr_out = l_q.rd_addr;
  assign rd_block_out = l_q.rd_blk;
  assign frame_busy_out = l_q.in_data;
endmodule
`default_nettype wire

// ### hdl/sfd_host.sv
// Serial frame host: builds frames, divides the core clock into the link clock
`timescale 1ns/1ps
`default_nettype none
module sfd_host #(
  parameter int SCLK_HALF = 4, // Core cycles per link clock half
  parameter bit FIXED_MODE = 1'b0 // Fixed-length framing when set
) (
  sfd_if.hst lnk, // Serial link, host side
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic cmd_valid_in, // Start a frame
  output logic cmd_ready_out, // Idle, command taken
  input wire logic cmd_write_in, // One for write
  input wire logic [sfd_pkg::ADDR_W-1:0] cmd_addr_in, // Start offset
  input wire logic [sfd_pkg::BLK_W-1:0] cmd_block_in, // Block select
  input wire logic [7:0] cmd_len_in, // Data bytes
  input wire logic [sfd_pkg::BYTE_W-1:0] wr_data_in, // Next write byte
  output logic wr_take_out, // Write byte taken
  output logic [sfd_pkg::BYTE_W-1:0] rd_data_out, // Read byte
  output logic rd_valid_out, // Read byte pulse
  output logic busy_out // Frame in progress
);
  typedef struct packed {
    sfd_pkg::sfd_host_st_e st;
    logic sel_n;
    logic sclk;
    logic mosi;
    logic wnr;
    logic [7:0] div;
    logic [11:0] bits;
    logic [11:0] total;
    logic [sfd_pkg::HDR_BITS-1:0] hdr;
    logic [sfd_pkg::BYTE_W-1:0] dbyte;
    logic [sfd_pkg::BYTE_W-1:0] rx;
    logic [sfd_pkg::BYTE_W-1:0] rd_data;
    logic rd_vld;
    logic wr_take;
    logic filt;
  } sfd_host_s;

  localparam sfd_host_s HOST_RST = '{st: sfd_pkg::SFD_H_IDLE, sel_n: 1'b1, default: '0};
  localparam logic [7:0] HALF_END = 8'(SCLK_HALF - 1);

  sfd_host_s q, n;
  logic miso_s2;
  logic miso_s3;
  logic [sfd_pkg::OM_W-1:0] om;
  logic [7:0] len;
  logic [sfd_pkg::HDR_BITS-1:0] new_hdr;
  logic half_done;

  // MISO enters through three stages
  sfd_sync3 #(.WIDTH(1)) u_miso_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in(lnk.miso),
    .s2_out(miso_s2),
    .s3_out(miso_s3)
  );

  // Mode bits and length, only 1/2/4 in fixed mode
  always_comb begin
    om = sfd_pkg::OM_VAR;
    len = (cmd_len_in == '0) ? sfd_pkg::N_ONE : cmd_len_in;
    if (FIXED_MODE) begin
      om = (cmd_len_in == sfd_pkg::N_FOUR) ? sfd_pkg::OM_FOUR :
           (cmd_len_in == sfd_pkg::N_TWO) ? sfd_pkg::OM_TWO : sfd_pkg::OM_ONE;
      len = (cmd_len_in == sfd_pkg::N_FOUR) ? sfd_pkg::N_FOUR :
            (cmd_len_in == sfd_pkg::N_TWO) ? sfd_pkg::N_TWO : sfd_pkg::N_ONE;
    end
    new_hdr = {cmd_addr_in, cmd_block_in, cmd_write_in, om};
  end

  assign half_done = (q.div == HALF_END);

  // Frame sequencer
  always_comb begin
    n = q;
    n.rd_vld = 1'b0;
    n.wr_take = 1'b0;
    n.div = half_done ? '0 : q.div + 8'h01;
    if (miso_s2 == miso_s3) begin
      n.filt = miso_s3;
    end
    case (q.st)
      sfd_pkg::SFD_H_IDLE: begin
        n.div = '0;
        n.sclk = 1'b0;
        n.sel_n = !FIXED_MODE;
        if (cmd_valid_in) begin
          n.sel_n = 1'b0;
          n.hdr = new_hdr;
          n.wnr = cmd_write_in;
          n.mosi = new_hdr[sfd_pkg::HDR_BITS-1];
          n.bits = '0;
          n.total = 12'(sfd_pkg::HDR_BITS) + {1'b0, len, 3'h0};
          n.st = sfd_pkg::SFD_H_LEAD;
        end
      end
      sfd_pkg::SFD_H_LEAD: begin
        if (half_done) begin
          n.st = sfd_pkg::SFD_H_RUN;
        end
      end
      sfd_pkg::SFD_H_RUN: begin
        if (half_done) begin
          n.sclk = !q.sclk;
          if (!q.sclk) begin
            // Sample read bit on rising edge
            n.bits = q.bits + 12'h001;
            n.rx = {q.rx[sfd_pkg::BYTE_W-2:0], q.filt};
            if (q.bits >= 12'(sfd_pkg::HDR_BITS) && q.bits[2:0] == 3'(sfd_pkg::LAST_BIT) && !q.wnr) begin
              n.rd_vld = 1'b1;
              n.rd_data = {q.rx[sfd_pkg::BYTE_W-2:0], q.filt};
            end
          end else if (q.bits == q.total) begin
            n.st = sfd_pkg::SFD_H_TAIL;
            n.mosi = 1'b0;
          end else if (q.bits < 12'(sfd_pkg::HDR_BITS)) begin
            n.mosi = q.hdr[sfd_pkg::LAST_HDR_EDGE - q.bits[4:0]];
          end else if (q.bits[2:0] == '0) begin
            n.dbyte = wr_data_in;
            n.wr_take = q.wnr;
            n.mosi = q.wnr & wr_data_in[sfd_pkg::BYTE_W-1];
          end else begin
            n.mosi = q.wnr & q.dbyte[3'(sfd_pkg::BYTE_W-1) - q.bits[2:0]];
          end
        end
      end
      sfd_pkg::SFD_H_TAIL: begin
        if (half_done) begin
          n.sel_n = !FIXED_MODE;
          n.st = sfd_pkg::SFD_H_GAP;
        end
      end
      sfd_pkg::SFD_H_GAP: begin
        if (half_done) begin
          n.st = sfd_pkg::SFD_H_IDLE;
        end
      end
      default: begin
        n = HOST_RST;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q <= HOST_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign lnk.frame_select_n = q.sel_n;
  assign lnk.sclk = q.sclk;
  assign lnk.mosi = q.mosi;
  assign cmd_ready_out = (q.st == sfd_pkg::SFD_H_IDLE);
  assign wr_take_out = q.wr_take;
  assign rd_data_out = q.rd_data;
  assign rd_valid_out = q.rd_vld;
  assign busy_out = (q.st != sfd_pkg::SFD_H_IDLE);
endmodule
`default_nettype wire

// ### verification/sfd_link_checker.sv
// Timing and framing checks on the serial link wires
`timescale 1ns/1ps
`default_nettype none
module sfd_link_checker (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic frame_select_n, // Frame select, low
  input wire logic sclk, // Link clock
  input wire logic mosi, // Host to target data
  input wire logic miso // Target to host data
);
  logic sclk_q;
  logic [9:0] edge_q;
  logic [3:0] low_q;
  logic [1:0] mode_q;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Rising edges per frame, low time of the clock, header mode bits
  always_ff @(posedge core_clk_in) begin
    sclk_q <= sclk;
    if (rst_in || frame_select_n) begin
      edge_q <= 10'h000;
    end else if (sclk && !sclk_q) begin
      edge_q <= edge_q + 10'h001;
    end
    if (sclk) begin
      low_q <= 4'h0;
    end else if (low_q != 4'hF) begin
      low_q <= low_q + 4'h1;
    end
    if (sclk && !sclk_q && (edge_q == 10'h016 || edge_q == 10'h017)) begin
      mode_q <= {mode_q[0], mosi};
    end
  end
  a_sclk_idle: assert property (frame_select_n |-> !sclk) else $error("link clock high outside a frame");
  // host data moves on falling edge
  a_mosi_fall: assert property ($changed(mosi) && !frame_select_n && !$past(frame_select_n) |-> !sclk)
    else $error("host data changed while clock high");
  a_miso_rise: assert property ($changed(miso) && !frame_select_n |-> sclk)
    else $error("target data changed while clock low");
  a_frame_whole: assert property ($rose(frame_select_n) |-> edge_q >= 10'h020 && edge_q[2:0] == 3'h0)
    else $error("frame ended off a byte boundary");
  a_mode_var: assert property (edge_q == 10'h018 |-> mode_q == 2'h0) else $error("mode bits not zero");
  a_sel_lead: assert property ($fell(frame_select_n) |-> !sclk [*4]) else $error("clock rose too soon");
  a_sel_tail: assert property ($rose(frame_select_n) |-> low_q >= 4'h4) else $error("select rose too soon");
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("clock half wrong");
endmodule
`default_nettype wire

// ### verification/sfd_tb_top.sv
// Bench joining a variable-mode and a fixed-mode host to two targets
`timescale 1ns/1ps
`default_nettype none
module sfd_tb_top;
  typedef struct packed {
    logic wr;
    logic p;
    logic [15:0] a;
    logic [4:0] b;
    logic [7:0] n;
    logic [7:0] d;
    logic [7:0] e;
  } sfd_row_s;
  localparam sfd_row_s ROWS [11] = '{
    '{1'h1, 1'h0, 16'h0018, 5'h00, 8'h01, 8'hAA, 8'h01}, '{1'h1, 1'h0, 16'h0040, 5'h06, 8'h05, 8'h11, 8'h05},
    '{1'h1, 1'h0, 16'hFFFE, 5'h1F, 8'h03, 8'hF0, 8'h03}, '{1'h0, 1'h0, 16'h0003, 5'h1D, 8'h01, 8'h00, 8'h01},
    '{1'h0, 1'h0, 16'h0100, 5'h0F, 8'h05, 8'h00, 8'h05}, '{1'h1, 1'h1, 16'h1000, 5'h01, 8'h01, 8'h20, 8'h01},
    '{1'h1, 1'h1, 16'h1100, 5'h02, 8'h02, 8'h30, 8'h02}, '{1'h1, 1'h1, 16'h1200, 5'h03, 8'h04, 8'h40, 8'h04},
    '{1'h0, 1'h1, 16'h2000, 5'h04, 8'h01, 8'h00, 8'h01}, '{1'h0, 1'h1, 16'h2100, 5'h05, 8'h02, 8'h00, 8'h02},
    '{1'h0, 1'h1, 16'hFFFF, 5'h06, 8'h04, 8'h00, 8'h04}};
  logic clk;
  logic rst;
  logic [1:0] vld, rdy, bsy, rv, tk, stb, rq, fb;
  logic [7:0] rdo [2], wdo [2], rdd [2];
  logic [15:0] wa [2], ra [2];
  logic [4:0] wb [2], rb [2];
  logic [7:0] wdat;
  sfd_row_s cur;
  int error_cnt, n_checks, gn, rn, tkn;
  logic [15:0] ga [64];
  logic [7:0] gd [64], rd [64];
  logic [4:0] gb [64];
  // Contents of the addressed store, as served to reads
  function automatic logic [7:0] mem(input logic [15:0] a, input logic [4:0] b);
    return a[7:0] ^ a[15:8] ^ {3'h0, b};
  endfunction
  genvar g;
  for (g = 0; g < 2; g++) begin : pr
    sfd_if lk ();
    sfd_host #(.SCLK_HALF(4), .FIXED_MODE(g == 1)) sfd_host_i (.lnk(lk), .core_clk_in(clk), .rst_in(rst),
      .cmd_valid_in(vld[g]), .cmd_ready_out(rdy[g]), .cmd_write_in(cur.wr), .cmd_addr_in(cur.a),
      .cmd_block_in(cur.b), .cmd_len_in(cur.n), .wr_data_in(wdat), .wr_take_out(tk[g]),
      .rd_data_out(rdo[g]), .rd_valid_out(rv[g]), .busy_out(bsy[g]));
    sfd_target sfd_target_i (.lnk(lk), .core_clk_in(clk), .rst_in(rst), .wr_stb_out(stb[g]),
      .wr_addr_out(wa[g]), .wr_block_out(wb[g]), .wr_data_out(wdo[g]), .rd_req_out(rq[g]),
      .rd_addr_out(ra[g]), .rd_block_out(rb[g]), .rd_data_in(rdd[g]), .frame_busy_out(fb[g]));
    // Read byte registered on the link edge after the request
    always @(posedge lk.sclk) begin
      if (rq[g] === 1'h1) begin
        rdd[g] <= mem(ra[g], rb[g]);
      end
    end
  end
  sfd_link_checker sfd_link_checker_i (.core_clk_in(clk), .rst_in(rst), .frame_select_n(pr[0].lk.frame_select_n),
    .sclk(pr[0].lk.sclk), .mosi(pr[0].lk.mosi), .miso(pr[0].lk.miso));
  // Collect stored writes, returned read bytes and byte takes
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (stb[p] === 1'h1 && gn < 64) begin
        ga[gn] = wa[p];
        gd[gn] = wdo[p];
        gb[gn] = wb[p];
        gn++;
      end
      if (rv[p] === 1'h1 && rn < 64) begin
        rd[rn] = rdo[p];
        rn++;
      end
    end
    if (tk !== 2'h0) tkn++;
  end
  // Next write byte follows the take count
  always @(negedge clk) wdat <= cur.d + tkn[7:0];
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: value %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic start(input sfd_row_s r);
    cur = r;
    gn = 0;
    rn = 0;
    tkn = 0;
    vld[r.p] = 1'h1;
    @(negedge clk);
    vld[r.p] = 1'h0;
  endtask
  // One frame: issue, wait for the end, compare every byte
  task automatic run(input sfd_row_s r);
    int k;
    start(r);
    k = 0;
    while (bsy[r.p] !== 1'h0 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    chk_b(bsy[r.p], 1'h0);
    repeat (20) @(negedge clk);
    chk_b(rdy[r.p], 1'h1);
    chk_v(r.wr ? 16'(gn) : 16'(rn), {8'h00, r.e});
    for (int j = 0; j < r.e; j++) begin
      if (r.wr) begin
        chk_v(ga[j], r.a + 16'(j));
        chk_v({8'h00, gd[j]}, {8'h00, r.d + 8'(j)});
        chk_v({11'h000, gb[j]}, {11'h000, r.b});
      end else begin
        chk_v({8'h00, rd[j]}, {8'h00, mem(r.a + 16'(j), r.b)});
      end
    end
    chk_b(r.p ? pr[1].lk.sclk : pr[0].lk.sclk, 1'h0);
    chk_b(r.p ? pr[1].lk.frame_select_n : pr[0].lk.frame_select_n, ~r.p);
    $display("test done: write %0d offset %0h length %0d", r.wr, r.a, r.n);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Core clock, 20 ns
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Watchdog against a hung link
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    close_out;
  end
  // Main sequence: table rows, then reset in mid-frame
  initial begin
    rst = 1'h1;
    vld = 2'h0;
    cur = '0;
    wdat = 8'h00;
    rdd[0] = 8'h00;
    rdd[1] = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    gn = 0;
    rn = 0;
    tkn = 0;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      run(ROWS[i]);
    end
    start('{1'h1, 1'h0, 16'h0050, 5'h02, 8'h05, 8'h30, 8'h05});
    repeat (300) @(negedge clk);
    rst = 1'h1;
    repeat (4) @(negedge clk);
    chk_b(pr[0].lk.frame_select_n, 1'h1);
    chk_b(pr[0].lk.sclk, 1'h0);
    chk_b(fb[0], 1'h0);
    chk_b(stb[0], 1'h0);
    repeat (8) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    chk_b(pr[1].lk.frame_select_n, 1'h0);
    $display("test done: reset in mid-frame");
    run('{1'h1, 1'h0, 16'h0050, 5'h02, 8'h00, 8'h77, 8'h01});
    close_out;
  end
endmodule
`default_nettype wire
